//--- include/boot_strap_pkg.sv
package boot_strap_pkg;
    // ==========================================
    // strap bank layout
    localparam int DIP_W = 8;
    localparam int DIP_PREV_OS = 0;
    localparam int DIP_STAY_BOOT = 1;
    localparam int DIP_WDOG_SUP = 2;
    localparam int DIP_FW_LOCK = 3;
    localparam int DIP_NET_CLR = 7;
    localparam logic [DIP_W-1:0] DIP_ALL_ON = 8'hff;
    localparam logic [DIP_W-1:0] DIP_RESET = 8'h00;

    // ==========================================
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int LED_STEP_MS = 100;
    localparam int LED_STEP_CYCLES = CLK_HZ / 1000 * LED_STEP_MS;
    localparam int SETTLE_CYCLES = 4;
    localparam int LED_N = 3;

    // ==========================================
    // mode switch, sequencer, led patterns
    typedef enum logic [1:0] {
        POS_TERM = 2'b00,
        POS_RUN = 2'b01,
        POS_STOP = 2'b10
    } pos_e;

    typedef enum logic [3:0] {
        SEQ_IDLE = 4'b0000,
        SEQ_RUN1 = 4'b0001,
        SEQ_TERM1 = 4'b0010,
        SEQ_RUN2 = 4'b0011,
        SEQ_TERM2 = 4'b0100,
        SEQ_STOP1 = 4'b0101,
        SEQ_ARMED = 4'b0110,
        SEQ_COMMIT = 4'b0111,
        SEQ_ERASE = 4'b1000
    } seq_e;

    typedef enum logic [1:0] {
        PAT_OFF = 2'b00,
        PAT_BOUNCE = 2'b01,
        PAT_CHASE = 2'b10,
        PAT_SOLID = 2'b11
    } pat_e;

    typedef struct packed {
        logic [LED_N-1:0] red;
        logic [LED_N-1:0] green;
    } led_bank_s;

    typedef struct packed {
        logic module_id;
        logic module_name;
        logic module_desc;
        logic ip_addr;
        logic subnet_mask;
        logic gateway;
        logic sys_config;
        logic mem_config;
        logic control_logic;
        logic documentation;
        logic user_accounts;
    } erase_scope_s;

    localparam erase_scope_s SCOPE_NONE = 11'h000;
    localparam erase_scope_s SCOPE_NET = 11'h7e0;
    localparam erase_scope_s SCOPE_ALL = 11'h7ff;
    localparam led_bank_s LED_OFF = 6'h00;
    localparam led_bank_s LED_GREEN_ALL = 6'h07;
endpackage : boot_strap_pkg

//--- rtl/pin_sync3.sv
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins and settled copy
    input wire logic [W-1:0] pin,
    output logic [W-1:0] stable_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    // a bit moves only where stages two and three agree
    wire logic [W-1:0] stable_d = (s2_q & s3_q) | (stable_q & (s2_q | s3_q));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            stable_q <= '0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stable_q <= stable_d;
        end
    end
endmodule : pin_sync3

//--- rtl/led_pattern.sv
`timescale 1ns/1ps
module led_pattern
    import boot_strap_pkg::*;
#(
    parameter int STEP_CYCLES = LED_STEP_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pattern select and bank drive
    input wire pat_e pat,
    output led_bank_s bank_q
);
    localparam int CW = $clog2(STEP_CYCLES + 1);
    localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYCLES - 1);

    logic [CW-1:0] div_q;
    logic [1:0] idx_q;
    logic color_q;
    wire logic tick = (div_q == STEP_LAST);
    // bounce walks 0,1,2,1; chase walks 0,1,2
    wire logic [1:0] idx_last = (pat == PAT_BOUNCE) ? 2'h3 : 2'h2;
    wire logic [1:0] led_pos = (idx_q == 2'h3) ? 2'h1 : idx_q;
    wire logic [LED_N-1:0] one_hot = LED_N'(3'h4 >> led_pos);
    wire logic [LED_N-1:0] dot_g = color_q ? '0 : one_hot;
    wire logic [LED_N-1:0] dot_r = color_q ? one_hot : '0;
    wire led_bank_s moving = {dot_r, dot_g};
    wire led_bank_s bank_d = (pat == PAT_SOLID) ? LED_GREEN_ALL :
                             (pat == PAT_OFF) ? LED_OFF : moving;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
            idx_q <= '0;
            color_q <= 1'b0;
            bank_q <= LED_OFF;
        end else begin
            div_q <= tick ? '0 : div_q + 1'b1;
            if (tick) begin
                idx_q <= (idx_q >= idx_last) ? 2'h0 : idx_q + 2'h1;
                color_q <= ~color_q;
            end
            bank_q <= bank_d;
        end
    end
endmodule : led_pattern

//--- rtl/boot_strap_reset_sequencer.sv
// Contract
// R1 - straps are captured once after power-up; later changes are ignored
// R2 - switch 0 on selects the previously stored operating system
// R3 - switch 1 on keeps the device in the boot loader, no OS load
// R4 - watchdog stays enabled; switch 2 blocks forced and debug trips
// R5 - switch 3 on locks firmware and gate array updates
// R6 - switch 7 requests network reset, valid only with switch 1
// R7 - all eight switches on select the clear-everything operation
// R8 - every switch reads off after reset until set
// R9 - clear operations are accepted only while in the boot loader
// R10 - operator sets only switches 1 and 7 for network-only clear
// R11 - network clear erases id, name, description, ip, mask, gateway only
// R12 - boot loader bounces left three leds, alternating red and green
// R13 - run,term,run,term,stop,term from term arms; left leds steady
// R14 - armed state abandons on move to run or power loss
// R15 - from armed, stop commits and lights right three leds
// R16 - committed state ignores every switch move but term; only power loss aborts
// R17 - term from committed erases: power-up pattern, rom led, then bounce
// R18 - clear-all erases network, configs, logic, docs, accounts
// R19 - low battery lights fault yellow and sets warning flag until good
// R20 - any out-of-order move before commit returns to idle at term
`timescale 1ns/1ps
module boot_strap_reset_sequencer
    import boot_strap_pkg::*;
#(
    parameter int STEP_CYCLES = LED_STEP_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // strap and switch pins
    input wire logic [DIP_W-1:0] dip_pin,
    input wire logic mode_run_pin,
    input wire logic mode_stop_pin,
    input wire logic battery_low_pin,
    // watchdog sources, same clock
    input wire logic force_wdog_req,
    input wire logic debug_wdog_req,
    // storage rewrite handshake
    input wire logic erase_done,
    // boot selection
    output logic straps_valid_q,
    output logic os_load_en_q,
    output logic boot_prev_os_q,
    output logic fw_update_lock_q,
    output logic wdog_enable_q,
    output logic wdog_trip_q,
    // clear operations
    output logic net_clear_sel_q,
    output logic clear_all_sel_q,
    output logic erase_req_q,
    output erase_scope_s erase_scope_q,
    // indicators
    output led_bank_s left_led_q,
    output led_bank_s right_led_q,
    output logic rom_led_q,
    output logic fault_led_yellow_q,
    output logic cell_voltage_warning_flag_q
);
    // ==========================================
    // pin synchronisers
    localparam int SYNC_W = DIP_W + 3;
    localparam int SC_W = $clog2(SETTLE_CYCLES + 1);
    localparam logic [SC_W-1:0] SETTLE_LAST = SC_W'(SETTLE_CYCLES);

    logic [SYNC_W-1:0] pin_stable;

    pin_sync3 #(
        .W(SYNC_W)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .pin({battery_low_pin, mode_stop_pin, mode_run_pin, dip_pin}),
        .stable_q(pin_stable)
    );

    wire logic [DIP_W-1:0] dip_now = pin_stable[DIP_W-1:0];
    wire logic run_now = pin_stable[DIP_W];
    wire logic stop_now = pin_stable[DIP_W+1];
    wire logic bat_low = pin_stable[DIP_W+2];

    // ==========================================
    // strap capture
    logic [SC_W-1:0] settle_q;
    logic [DIP_W-1:0] strap_q;
    // wait for the chain to fill so the capture sees the real pins
    wire logic capture = !straps_valid_q && (settle_q == SETTLE_LAST);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settle_q <= '0;
            strap_q <= DIP_RESET; // [R8]
            straps_valid_q <= 1'b0;
        end else begin
            if (!straps_valid_q && !capture) begin
                settle_q <= settle_q + 1'b1;
            end
            if (capture) begin
                strap_q <= dip_now; // [R1]
                straps_valid_q <= 1'b1;
            end
        end
    end

    wire logic stay_boot = strap_q[DIP_STAY_BOOT];
    wire logic all_sel = (strap_q == DIP_ALL_ON); // [R7]
    wire logic net_sel = strap_q[DIP_NET_CLR] && stay_boot && !all_sel; // [R6]
    wire logic seq_en = straps_valid_q && stay_boot && (net_sel || all_sel); // [R9]
    wire logic wdog_block = strap_q[DIP_WDOG_SUP];
    wire erase_scope_s scope_sel = all_sel ? SCOPE_ALL : SCOPE_NET; // [R11] [R18]

    // ==========================================
    // mode switch position
    pos_e pos_q;
    pos_e pos_prev_q;
    wire pos_e pos_now = (run_now && !stop_now) ? POS_RUN :
                         (stop_now && !run_now) ? POS_STOP : POS_TERM;
    wire logic pos_chg = (pos_q != pos_prev_q);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos_q <= POS_TERM;
            pos_prev_q <= POS_TERM;
        end else begin
            pos_q <= pos_now;
            pos_prev_q <= pos_q;
        end
    end

    // ==========================================
    // clear sequence detector
    seq_e seq_q;
    seq_e seq_d;

    // expected next position for each step before arming
    wire pos_e want = (seq_q == SEQ_RUN1 || seq_q == SEQ_RUN2 ||
                       seq_q == SEQ_STOP1) ? POS_TERM :
                      (seq_q == SEQ_TERM2) ? POS_STOP : POS_RUN;

    always_comb begin
        seq_d = seq_q;
        case (seq_q)
            SEQ_IDLE: begin
                if (pos_chg && pos_q == POS_RUN && pos_prev_q == POS_TERM) begin
                    seq_d = SEQ_RUN1; // [R13]
                end
            end
            SEQ_RUN1, SEQ_TERM1, SEQ_RUN2, SEQ_TERM2, SEQ_STOP1: begin
                if (pos_chg) begin
                    // out-of-order move restarts from scratch
                    seq_d = (pos_q == want) ? seq_e'(seq_q + 4'h1) : SEQ_IDLE; // [R13] [R20]
                end
            end
            SEQ_ARMED: begin
                if (pos_chg && pos_q == POS_STOP) begin
                    seq_d = SEQ_COMMIT; // [R15]
                end else if (pos_chg && pos_q == POS_RUN) begin
                    seq_d = SEQ_IDLE; // [R14]
                end
            end
            SEQ_COMMIT: begin
                // no way back: only power loss (reset) cancels
                if (pos_chg && pos_q == POS_TERM) begin
                    seq_d = SEQ_ERASE; // [R16] [R17]
                end
            end
            SEQ_ERASE: begin
                if (erase_done) begin
                    seq_d = SEQ_IDLE; // [R17]
                end
            end
            default: begin
                seq_d = SEQ_IDLE;
            end
        endcase
        if (!seq_en) begin
            seq_d = SEQ_IDLE; // [R9]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq_q <= SEQ_IDLE;
        end else begin
            seq_q <= seq_d;
        end
    end

    // ==========================================
    // led pattern selection
    pat_e pat_sel;
    led_bank_s left_pat;

    assign pat_sel = !straps_valid_q ? PAT_OFF :
                     (seq_q == SEQ_ERASE) ? PAT_CHASE : // [R17]
                     (seq_q == SEQ_ARMED) ? PAT_SOLID : // [R13]
                     (seq_q == SEQ_COMMIT) ? PAT_OFF :
                     stay_boot ? PAT_BOUNCE : PAT_OFF; // [R12]

    led_pattern #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_left (
        .clk(clk),
        .rst(rst),
        .pat(pat_sel),
        .bank_q(left_pat)
    );

    wire led_bank_s right_d = (seq_q == SEQ_COMMIT) ? LED_GREEN_ALL : LED_OFF; // [R15]
    wire logic erase_start = (seq_q != SEQ_ERASE) && (seq_d == SEQ_ERASE);

    // ==========================================
    // output registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            os_load_en_q <= 1'b0;
            boot_prev_os_q <= 1'b0;
            fw_update_lock_q <= 1'b0;
            wdog_enable_q <= 1'b1;
            wdog_trip_q <= 1'b0;
            net_clear_sel_q <= 1'b0;
            clear_all_sel_q <= 1'b0;
            erase_req_q <= 1'b0;
            erase_scope_q <= SCOPE_NONE;
            left_led_q <= LED_OFF;
            right_led_q <= LED_OFF;
            rom_led_q <= 1'b0;
            fault_led_yellow_q <= 1'b0;
            cell_voltage_warning_flag_q <= 1'b0;
        end else begin
            os_load_en_q <= straps_valid_q && !stay_boot; // [R3]
            boot_prev_os_q <= straps_valid_q && strap_q[DIP_PREV_OS]; // [R2]
            fw_update_lock_q <= strap_q[DIP_FW_LOCK]; // [R5]
            wdog_enable_q <= 1'b1; // [R4]
            wdog_trip_q <= (force_wdog_req || debug_wdog_req) && !wdog_block; // [R4]
            net_clear_sel_q <= straps_valid_q && net_sel; // [R6]
            clear_all_sel_q <= straps_valid_q && all_sel; // [R7]
            erase_req_q <= erase_start; // [R17]
            erase_scope_q <= (seq_d == SEQ_ERASE) ? scope_sel : SCOPE_NONE; // [R11] [R18]
            left_led_q <= left_pat;
            right_led_q <= right_d;
            rom_led_q <= (seq_q == SEQ_ERASE); // [R17]
            fault_led_yellow_q <= bat_low; // [R19]
            cell_voltage_warning_flag_q <= bat_low; // [R19]
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence arm_walk;
        seq_q == SEQ_STOP1 ##1 seq_q == SEQ_ARMED;
    endsequence

    sequence commit_then_term;
        seq_q == SEQ_COMMIT && pos_chg && pos_q == POS_TERM;
    endsequence

    a_strap_frozen: assert property (straps_valid_q |=> $stable(strap_q) && straps_valid_q) // [R1]
        else $error("strap bank changed after capture");
    a_prev_os_sel: assert property ( // [R2]
        $past(straps_valid_q) |-> boot_prev_os_q == $past(strap_q[DIP_PREV_OS]))
        else $error("previous os select does not follow strap 0");
    a_stay_boot: assert property (straps_valid_q && stay_boot |=> !os_load_en_q) // [R3]
        else $error("os load enabled while staying in boot loader");
    a_wdog_block: assert property (wdog_block |=> !wdog_trip_q && wdog_enable_q) // [R4]
        else $error("watchdog trip not blocked by strap 2");
    a_trip_pass: assert property ( // [R4]
        (force_wdog_req || debug_wdog_req) && !wdog_block |=> wdog_trip_q)
        else $error("watchdog request did not trip");
    a_fw_lock: assert property (strap_q[DIP_FW_LOCK] |=> fw_update_lock_q) // [R5]
        else $error("firmware update not locked");
    a_net_needs_boot: assert property (net_clear_sel_q |-> strap_q[DIP_STAY_BOOT]) // [R6]
        else $error("network clear without strap 1");
    a_only_bootldr: assert property (!seq_en |=> seq_q == SEQ_IDLE) // [R9]
        else $error("clear sequence active outside boot loader");
    a_armed_lit: assert property (arm_walk |-> ##[1:2] left_led_q == LED_GREEN_ALL) // [R13]
        else $error("left bank not steady after arming");
    a_armed_abort: assert property ( // [R14]
        seq_q == SEQ_ARMED && pos_chg && pos_q == POS_RUN && seq_en |=> seq_q == SEQ_IDLE)
        else $error("armed state did not abandon on run");
    a_bad_order: assert property ( // [R20]
        seq_q == SEQ_TERM1 && pos_chg && pos_q != POS_RUN && seq_en |=> seq_q == SEQ_IDLE)
        else $error("out-of-order move did not restart the sequence");
    a_commit_right: assert property (seq_q == SEQ_COMMIT |=> right_led_q == LED_GREEN_ALL) // [R15]
        else $error("right bank not lit in commit");
    a_commit_hold: assert property ( // [R16]
        seq_q == SEQ_COMMIT && !(pos_chg && pos_q == POS_TERM) && seq_en |=> seq_q == SEQ_COMMIT)
        else $error("committed state left without term");
    a_erase_hold: assert property ( // [R16]
        seq_q == SEQ_ERASE && !erase_done |=> seq_q == SEQ_ERASE)
        else $error("erase cancelled before storage rewrite finished");
    a_erase_start: assert property ( // [R17]
        commit_then_term ##1 1'b1 |-> erase_req_q ##1 rom_led_q)
        else $error("erase not started with rom led");
    a_erase_scope: assert property ( // [R11]
        erase_req_q |-> erase_scope_q == (all_sel ? SCOPE_ALL : SCOPE_NET))
        else $error("erase scope does not match strap selection");
    a_batt_warn: assert property (bat_low |=> fault_led_yellow_q && cell_voltage_warning_flag_q) // [R19]
        else $error("low battery not indicated");
    a_batt_clear: assert property ( // [R19]
        !bat_low |=> !fault_led_yellow_q && !cell_voltage_warning_flag_q)
        else $error("battery warning kept with good battery");
endmodule : boot_strap_reset_sequencer

//--- tb/operator_model.sv
`timescale 1ns/1ps
module operator_model
    import boot_strap_pkg::*;
#(
    parameter int HOLD = 12
) (
    // clock
    input wire logic clk,
    // strap bank and mode switch
    output logic [DIP_W-1:0] dip_pin,
    output logic mode_run_pin,
    output logic mode_stop_pin
);
    // ==========================================
    // switch handling
    initial begin
        dip_pin = DIP_RESET;
        mode_run_pin = 1'b0;
        mode_stop_pin = 1'b0;
    end

    // a real hand is slow: hold well past the settle delay
    task automatic move(input pos_e p, input int hold);
        @(posedge clk);
        #1;
        mode_run_pin = (p == POS_RUN);
        mode_stop_pin = (p == POS_STOP);
        repeat (hold) @(posedge clk);
        // return off the edge so callers never sample a launching edge
        #1;
    endtask : move

    task automatic set_dip(input logic [DIP_W-1:0] v);
        dip_pin = v;
    endtask : set_dip

    task automatic net_only();
        set_dip(8'h82);
    endtask : net_only

    task automatic arm();
        move(POS_RUN, HOLD);
        move(POS_TERM, HOLD);
        move(POS_RUN, HOLD);
        move(POS_TERM, HOLD);
        move(POS_STOP, HOLD);
        move(POS_TERM, HOLD);
    endtask : arm
endmodule : operator_model

//--- tb/tb.sv
`timescale 1ns/1ps
module tb
    import boot_strap_pkg::*;
;
    // ==========================================
    // signals
    localparam int STEP = 8;
    logic clk, rst, mode_run_pin, mode_stop_pin, battery_low_pin;
    logic force_wdog_req, debug_wdog_req, erase_done;
    logic [DIP_W-1:0] dip_pin;
    logic straps_valid_q, os_load_en_q, boot_prev_os_q, fw_update_lock_q;
    logic wdog_enable_q, wdog_trip_q, net_clear_sel_q, clear_all_sel_q, erase_req_q;
    logic rom_led_q, fault_led_yellow_q, cell_voltage_warning_flag_q;
    erase_scope_s erase_scope_q;
    led_bank_s left_led_q, right_led_q;
    int miscompares = 0;
    int n_compared = 0;

    boot_strap_reset_sequencer #(.STEP_CYCLES(STEP)) boot_strap_reset_sequencer_inst (
        .clk(clk), .rst(rst), .dip_pin(dip_pin), .mode_run_pin(mode_run_pin),
        .mode_stop_pin(mode_stop_pin), .battery_low_pin(battery_low_pin),
        .force_wdog_req(force_wdog_req), .debug_wdog_req(debug_wdog_req),
        .erase_done(erase_done), .straps_valid_q(straps_valid_q),
        .os_load_en_q(os_load_en_q), .boot_prev_os_q(boot_prev_os_q),
        .fw_update_lock_q(fw_update_lock_q), .wdog_enable_q(wdog_enable_q),
        .wdog_trip_q(wdog_trip_q), .net_clear_sel_q(net_clear_sel_q),
        .clear_all_sel_q(clear_all_sel_q), .erase_req_q(erase_req_q),
        .erase_scope_q(erase_scope_q), .left_led_q(left_led_q), .right_led_q(right_led_q),
        .rom_led_q(rom_led_q), .fault_led_yellow_q(fault_led_yellow_q),
        .cell_voltage_warning_flag_q(cell_voltage_warning_flag_q)
    );

    operator_model operator_model_inst (
        .clk(clk), .dip_pin(dip_pin), .mode_run_pin(mode_run_pin),
        .mode_stop_pin(mode_stop_pin)
    );

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // ==========================================
    // helpers
    task automatic test_done();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
            miscompares++;
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic timeout(input string what);
        $display("wrong value %s expected 1 seen timeout", what);
        miscompares++;
        test_done();
    endtask : timeout

    // power cycle with whatever straps the operator has set
    task automatic power_up();
        int i;
        rst = 1'b1;
        tick(5);
        rst = 1'b0;
        for (i = 0; i < 20 && straps_valid_q !== 1'b1; i++) tick(1);
        if (i == 20) timeout("straps_valid_q");
        tick(2);
    endtask : power_up

    // bounce: one lamp at a time, top and bottom reached, both colours
    task automatic chk_bounce();
        int bad;
        logic [3:0] seen;
        bad = 0;
        seen = 4'h0;
        repeat (8 * STEP) begin
            tick(1);
            if ($countones(left_led_q) != 1) bad++;
            seen |= {left_led_q[5] | left_led_q[2], left_led_q[3] | left_led_q[0],
                     |left_led_q.red, |left_led_q.green};
        end
        chk("bounce extra lamps", 0, bad);
        chk("bounce coverage", 4'hf, seen);
    endtask : chk_bounce

    task automatic run_erase(input erase_scope_s exp);
        int i;
        operator_model_inst.move(POS_TERM, 0);
        for (i = 0; i < 20 && erase_req_q !== 1'b1; i++) tick(1);
        if (i == 20) timeout("erase_req_q");
        chk("erase_scope_q", exp, erase_scope_q);
        tick(1);
        chk("rom_led_q on", 1, rom_led_q);
        chk("right_led_q erase", LED_OFF, right_led_q);
        erase_done = 1'b1;
        tick(1);
        chk("left_led_q chase lamps", 1, $countones(left_led_q));
        erase_done = 1'b0;
        tick(3);
        chk("rom_led_q off", 0, rom_led_q);
        chk("erase_scope_q cleared", SCOPE_NONE, erase_scope_q);
        chk_bounce();
    endtask : run_erase

    // ==========================================
    // scenarios
    initial begin
        rst = 1'b1;
        battery_low_pin = 1'b0;
        force_wdog_req = 1'b0;
        debug_wdog_req = 1'b0;
        erase_done = 1'b0;
        power_up();
        chk("os_load_en_q", 1, os_load_en_q);
        chk("boot_prev_os_q", 0, boot_prev_os_q);
        chk("fw_update_lock_q", 0, fw_update_lock_q);
        chk("net_clear_sel_q", 0, net_clear_sel_q);
        chk("wdog_enable_q", 1, wdog_enable_q);
        operator_model_inst.set_dip(DIP_ALL_ON);
        tick(20);
        chk("clear_all_sel_q late straps", 0, clear_all_sel_q);
        chk("os_load_en_q late straps", 1, os_load_en_q);
        force_wdog_req = 1'b1;
        tick(2);
        chk("wdog_trip_q forced", 1, wdog_trip_q);
        force_wdog_req = 1'b0;
        debug_wdog_req = 1'b1;
        tick(2);
        chk("wdog_trip_q debug", 1, wdog_trip_q);
        debug_wdog_req = 1'b0;
        tick(2);
        chk("wdog_trip_q idle", 0, wdog_trip_q);
        battery_low_pin = 1'b1;
        tick(10);
        chk("battery low", 2'b11, {fault_led_yellow_q, cell_voltage_warning_flag_q});
        battery_low_pin = 1'b0;
        tick(10);
        chk("battery good", 2'b00, {fault_led_yellow_q, cell_voltage_warning_flag_q});

        operator_model_inst.set_dip(8'h0d);
        power_up();
        chk("boot_prev_os_q", 1, boot_prev_os_q);
        chk("fw_update_lock_q", 1, fw_update_lock_q);
        debug_wdog_req = 1'b1;
        force_wdog_req = 1'b1;
        tick(3);
        chk("wdog_trip_q suppressed", 0, wdog_trip_q);
        chk("wdog_enable_q suppressed", 1, wdog_enable_q);
        debug_wdog_req = 1'b0;
        force_wdog_req = 1'b0;

        operator_model_inst.set_dip(8'h80);
        power_up();
        chk("net_clear_sel_q no loader", 0, net_clear_sel_q);
        operator_model_inst.arm();
        chk("armed outside loader", 0, left_led_q === LED_GREEN_ALL);
        operator_model_inst.move(POS_STOP, 12);
        chk("right_led_q outside loader", LED_OFF, right_led_q);
        operator_model_inst.move(POS_TERM, 12);

        operator_model_inst.net_only();
        power_up();
        chk("os_load_en_q loader", 0, os_load_en_q);
        chk("net_clear_sel_q", 1, net_clear_sel_q);
        chk("clear_all_sel_q net", 0, clear_all_sel_q);
        chk_bounce();
        operator_model_inst.move(POS_RUN, 12);
        operator_model_inst.move(POS_TERM, 12);
        operator_model_inst.move(POS_STOP, 12);
        operator_model_inst.move(POS_TERM, 12);
        chk("armed after bad order", 0, left_led_q === LED_GREEN_ALL);
        operator_model_inst.arm();
        chk("left_led_q armed", LED_GREEN_ALL, left_led_q);
        operator_model_inst.move(POS_RUN, 12);
        chk("armed after run", 0, left_led_q === LED_GREEN_ALL);
        operator_model_inst.move(POS_TERM, 12);
        operator_model_inst.arm();
        power_up();
        chk("armed after power loss", 0, left_led_q === LED_GREEN_ALL);
        operator_model_inst.arm();
        operator_model_inst.move(POS_STOP, 12);
        chk("right_led_q commit", LED_GREEN_ALL, right_led_q);
        operator_model_inst.move(POS_RUN, 12);
        chk("right_led_q after run", LED_GREEN_ALL, right_led_q);
        run_erase(SCOPE_NET);

        operator_model_inst.set_dip(DIP_ALL_ON);
        power_up();
        chk("clear_all_sel_q", 1, clear_all_sel_q);
        chk("net_clear_sel_q all", 0, net_clear_sel_q);
        operator_model_inst.arm();
        operator_model_inst.move(POS_STOP, 12);
        run_erase(SCOPE_ALL);
        test_done();
    end
endmodule : tb
